// file: verilog/rcr_pkg.sv
// Package for the regulator control register bank.
// Assumes an 8-bit register port fed by an external serial target front end.
package rcr_pkg;
   // Register addresses
   localparam logic [7:0] ADDR_PART_IDENTITY = 8'h00;
   localparam logic [7:0] ADDR_FUSE_VERSION  = 8'h01;
   localparam logic [7:0] ADDR_SWITCHER_A    = 8'h02;
   localparam logic [7:0] ADDR_PG_CFG_A      = 8'h15;
   localparam logic [7:0] ADDR_PG_CFG_B      = 8'h16;
   localparam logic [7:0] ADDR_POWER_GOOD_FAULT_FLAGS      = 8'h17;
   localparam logic [7:0] ADDR_SW_RESET      = 8'h18;
   localparam logic [7:0] ADDR_TOP_INT_A     = 8'h19;
   localparam logic [7:0] ADDR_TOP_INT_B     = 8'h1a;
   localparam logic [7:0] ADDR_SW_INT        = 8'h1b;
   localparam logic [7:0] ADDR_LIN_INT       = 8'h1c;
   localparam logic [7:0] ADDR_TOP_STATUS    = 8'h1d;
   localparam logic [7:0] ADDR_SW_STATUS     = 8'h1e;
   localparam logic [7:0] ADDR_LIN_STATUS    = 8'h1f;
   localparam logic [7:0] ADDR_TOP_MASK_A    = 8'h20;
   localparam logic [7:0] ADDR_TOP_MASK_B    = 8'h21;
   localparam logic [7:0] ADDR_SW_MASK       = 8'h22;
   localparam logic [7:0] ADDR_LIN_MASK      = 8'h23;
   localparam logic [7:0] ADDR_LOAD_SEL      = 8'h24;
   localparam logic [7:0] ADDR_LOAD_HIGH     = 8'h25;
   localparam logic [7:0] ADDR_LOAD_LOW      = 8'h26;
   // Field positions
   localparam int BIT_FORCED_PWM  = 3;
   localparam int BIT_DISCHARGE   = 2;
   localparam int BIT_PIN_GATING  = 1;
   localparam int BIT_ENABLE      = 0;
   localparam int ID_MSB          = 7;
   localparam int ID_LSB          = 6;
   // Reset values, reserved identity bits and write masks
   localparam logic [7:0] RST_SWITCHER_A    = 8'h0f;
   localparam logic [5:0] PART_RESERVED_VAL = 6'h02;
   localparam logic [7:0] RST_ZERO          = 8'h00;
   localparam logic [7:0] MASK_CTRL_A       = 8'h0f;
   localparam logic [7:0] MASK_RO_FAULT     = 8'h0f;
   localparam logic [7:0] MASK_ONE_BIT      = 8'h01;
   localparam logic [7:0] MASK_INT_SUB      = 8'h77;
   localparam logic [7:0] MASK_TOP_MASK_A   = 8'h95;
   localparam logic [7:0] MASK_SUB_MASK     = 8'hdd;
   localparam logic [7:0] MASK_PG_CFG_B     = 8'h07;
   // Write sequencing
   typedef enum logic [1:0] {WR_IDLE, WR_ADDR, WR_DATA} rcr_wr_state_type;
   // Serial front-end byte transfer
   typedef struct packed {
      logic       start;
      logic       stop;
      logic       wr_valid;
      logic [7:0] wr_byte;
      logic       rd_req;
   } rcr_xfer_type;
   // Fuse defaults loaded in the memory-read state
   typedef struct packed {
      logic [1:0] part_id;
      logic [7:0] version;
      logic       forced_pwm;
      logic       pin_gating;
      logic       enable;
   } rcr_fuse_type;
endpackage

// file: verilog/rcr_regs.sv
// Regulator control register bank: identity, switcher A controls, fault/int/status/mask/load registers.
// Assumes a serial target front end delivering start/stop, write bytes and read requests synchronous to i_clk.
// Function
// - Control bit 3: 0 automatic mode, 1 forced pulse-width operation.
// - Control bit 2 connects discharge resistor while disabled; resets to one.
// - Control bit 1: 0 enable bit alone, 1 enable bit AND pin.
// - Control bit 0 enables the switcher, subject to pin gating.
// - Address zero bits 7:6 report identity code; writes ignored.
// - Address one reports eight-bit fuse version code, read only.
// - First write byte selects register address, next bytes carry data.
// - Index increments after each written data byte, never on reads.
// - Fuse-marked bits take defaults from fuse memory during memory-read state.
`timescale 1ns/10ps
module rcr_regs
   import rcr_pkg::*;
(
   // Clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   input  wire logic         i_ce,
   // Serial front end
   input  wire rcr_xfer_type i_xfer,
   output logic [7:0]        o_rd_data,
   // Fuse memory
   input  wire logic         i_fuse_load,
   input  wire rcr_fuse_type i_fuse,
   // Analog side
   input  wire logic         i_en_pin,
   input  wire logic         i_reg_a_on,
   input  wire logic [7:0]   i_power_good_fault_flags,
   input  wire logic [7:0]   i_top_status,
   input  wire logic [7:0]   i_sw_status,
   input  wire logic [7:0]   i_lin_status,
   input  wire logic [8:0]   i_load_current,
   input  wire logic [7:0]   i_top_int_set_a,
   input  wire logic         i_top_int_set_b,
   input  wire logic [7:0]   i_sw_int_set,
   input  wire logic [7:0]   i_lin_int_set,
   // Regulator controls
   output logic              o_reg_a_active,
   output logic              o_reg_a_forced_pwm_select,
   output logic              o_reg_a_discharge_on,
   output logic              o_sw_reset,
   output logic [7:0]        o_pg_config_a,
   output logic [7:0]        o_pg_config_b,
   output logic              o_load_sel
);
   localparam logic [7:0] PART_ID_CODE = 8'h01; // Arbitrary identity code

   rcr_wr_state_type wr_state_r;
   logic [7:0]       index_r;
   logic [7:0]       ctrl_a_r;
   logic [1:0]       part_id_r;
   logic [7:0]       version_r;
   logic [7:0]       pg_a_r, pg_b_r, rst_r;
   logic [7:0]       int_top_a_r, int_top_b_r, int_sw_r, int_lin_r;
   logic [7:0]       mask_top_a_r, mask_top_b_r, mask_sw_r, mask_lin_r;
   logic             load_sel_r;
   logic             wr_data;
   logic [7:0]       rd_nxt;

   // Data byte of a write transfer
   assign wr_data = i_xfer.wr_valid && (wr_state_r == WR_DATA);

   // Address then data byte sequencing
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         wr_state_r <= WR_IDLE;
      end else if (i_ce) begin
         if (i_xfer.stop) begin
            wr_state_r <= WR_IDLE;
         end else if (i_xfer.start) begin
            wr_state_r <= WR_ADDR;
         end else if (i_xfer.wr_valid && wr_state_r == WR_ADDR) begin
            wr_state_r <= WR_DATA;
         end
      end
   end

   // Register index
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         index_r <= RST_ZERO;
      end else if (i_ce) begin
         if (i_xfer.wr_valid && wr_state_r == WR_ADDR) begin
            index_r <= i_xfer.wr_byte;
         end else if (wr_data) begin
            index_r <= 8'(index_r + 8'h01);
         end
      end
   end

   // Switcher A control and fuse-loaded identity
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ctrl_a_r  <= RST_SWITCHER_A;
         part_id_r <= 2'h0;
         version_r <= RST_ZERO;
      end else if (i_ce) begin
         if (i_fuse_load) begin
            part_id_r                <= i_fuse.part_id;
            version_r                <= i_fuse.version;
            ctrl_a_r[BIT_FORCED_PWM] <= i_fuse.forced_pwm;
            ctrl_a_r[BIT_PIN_GATING] <= i_fuse.pin_gating;
            ctrl_a_r[BIT_ENABLE]     <= i_fuse.enable;
         end else if (wr_data && index_r == ADDR_SWITCHER_A) begin
            ctrl_a_r <= i_xfer.wr_byte & MASK_CTRL_A;
         end
      end
   end

   // Plain configuration registers
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pg_a_r       <= RST_ZERO;
         pg_b_r       <= RST_ZERO;
         rst_r        <= RST_ZERO;
         mask_top_a_r <= RST_ZERO;
         mask_top_b_r <= RST_ZERO;
         mask_sw_r    <= RST_ZERO;
         mask_lin_r   <= RST_ZERO;
         load_sel_r   <= 1'b0;
      end else if (i_ce) begin
         rst_r <= RST_ZERO;
         if (wr_data) begin
            unique case (index_r)
               ADDR_PG_CFG_A:   pg_a_r       <= i_xfer.wr_byte;
               ADDR_PG_CFG_B:   pg_b_r       <= i_xfer.wr_byte & MASK_PG_CFG_B;
               ADDR_SW_RESET:   rst_r        <= i_xfer.wr_byte & MASK_ONE_BIT;
               ADDR_TOP_MASK_A: mask_top_a_r <= i_xfer.wr_byte & MASK_TOP_MASK_A;
               ADDR_TOP_MASK_B: mask_top_b_r <= i_xfer.wr_byte & MASK_ONE_BIT;
               ADDR_SW_MASK:    mask_sw_r    <= i_xfer.wr_byte & MASK_SUB_MASK;
               ADDR_LIN_MASK:   mask_lin_r   <= i_xfer.wr_byte & MASK_SUB_MASK;
               ADDR_LOAD_SEL:   load_sel_r   <= i_xfer.wr_byte[0];
               default: ;
            endcase
         end
      end
   end

   // Sticky interrupt flags, write one to clear, set wins
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         int_top_a_r <= RST_ZERO;
         int_top_b_r <= RST_ZERO;
         int_sw_r    <= RST_ZERO;
         int_lin_r   <= RST_ZERO;
      end else if (i_ce) begin
         int_top_a_r <= (int_top_a_r & ~((wr_data && index_r == ADDR_TOP_INT_A) ? i_xfer.wr_byte : 8'h00))
                        | i_top_int_set_a;
         int_top_b_r <= ((int_top_b_r & ~((wr_data && index_r == ADDR_TOP_INT_B) ? i_xfer.wr_byte : 8'h00))
                        | {7'h00, i_top_int_set_b}) & MASK_ONE_BIT;
         int_sw_r    <= ((int_sw_r & ~((wr_data && index_r == ADDR_SW_INT) ? i_xfer.wr_byte : 8'h00))
                        | i_sw_int_set) & MASK_INT_SUB;
         int_lin_r   <= ((int_lin_r & ~((wr_data && index_r == ADDR_LIN_INT) ? i_xfer.wr_byte : 8'h00))
                        | i_lin_int_set) & MASK_INT_SUB;
      end
   end

   // Read multiplexer, index held on reads
   always_comb begin
      rd_nxt = RST_ZERO;
      unique case (index_r)
         ADDR_PART_IDENTITY: rd_nxt = {part_id_r ^ PART_ID_CODE[1:0], PART_RESERVED_VAL};
         ADDR_FUSE_VERSION:  rd_nxt = version_r;
         ADDR_SWITCHER_A:    rd_nxt = ctrl_a_r;
         ADDR_PG_CFG_A:      rd_nxt = pg_a_r;
         ADDR_PG_CFG_B:      rd_nxt = pg_b_r;
         ADDR_POWER_GOOD_FAULT_FLAGS:      rd_nxt = i_power_good_fault_flags & MASK_RO_FAULT;
         ADDR_SW_RESET:      rd_nxt = rst_r;
         ADDR_TOP_INT_A:     rd_nxt = int_top_a_r;
         ADDR_TOP_INT_B:     rd_nxt = int_top_b_r;
         ADDR_SW_INT:        rd_nxt = int_sw_r;
         ADDR_LIN_INT:       rd_nxt = int_lin_r;
         ADDR_TOP_STATUS:    rd_nxt = i_top_status;
         ADDR_SW_STATUS:     rd_nxt = {i_sw_status[7:4], i_sw_status[3:1], i_reg_a_on};
         ADDR_LIN_STATUS:    rd_nxt = i_lin_status;
         ADDR_TOP_MASK_A:    rd_nxt = mask_top_a_r;
         ADDR_TOP_MASK_B:    rd_nxt = mask_top_b_r;
         ADDR_SW_MASK:       rd_nxt = mask_sw_r;
         ADDR_LIN_MASK:      rd_nxt = mask_lin_r;
         ADDR_LOAD_SEL:      rd_nxt = {7'h00, load_sel_r};
         ADDR_LOAD_HIGH:     rd_nxt = {7'h00, i_load_current[8]};
         ADDR_LOAD_LOW:      rd_nxt = i_load_current[7:0];
         default:            rd_nxt = RST_ZERO;
      endcase
   end

   // Read data register
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rd_data <= RST_ZERO;
      end else if (i_ce && i_xfer.rd_req) begin
         o_rd_data <= rd_nxt;
      end
   end

   // Regulator control decode
   assign o_reg_a_active            = ctrl_a_r[BIT_ENABLE] && (!ctrl_a_r[BIT_PIN_GATING] || i_en_pin);
   assign o_reg_a_forced_pwm_select = ctrl_a_r[BIT_FORCED_PWM];
   assign o_reg_a_discharge_on      = ctrl_a_r[BIT_DISCHARGE] && !o_reg_a_active;
   assign o_sw_reset                = rst_r[0];
   assign o_pg_config_a             = pg_a_r;
   assign o_pg_config_b             = pg_b_r;
   assign o_load_sel                = load_sel_r;

   // Assertions
   a_gate_pin: assert property (@(posedge i_clk) disable iff (i_rst)
      (ctrl_a_r[BIT_PIN_GATING] && !i_en_pin) |-> !o_reg_a_active) else $error("pin gating ignored");
   a_enable_off: assert property (@(posedge i_clk) disable iff (i_rst)
      !ctrl_a_r[BIT_ENABLE] |-> !o_reg_a_active) else $error("active while disabled");
   a_discharge: assert property (@(posedge i_clk) disable iff (i_rst)
      (ctrl_a_r[BIT_DISCHARGE] && !o_reg_a_active) |-> o_reg_a_discharge_on) else $error("discharge missing");
   a_ctrl_write: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && !i_fuse_load && wr_data && index_r == ADDR_SWITCHER_A)
      |=> ctrl_a_r == ($past(i_xfer.wr_byte) & MASK_CTRL_A)) else $error("control write lost");
   a_id_ro: assert property (@(posedge i_clk) disable iff (i_rst)
      !i_fuse_load |=> $stable(part_id_r)) else $error("identity changed");
   a_ver_ro: assert property (@(posedge i_clk) disable iff (i_rst)
      !i_fuse_load |=> $stable(version_r)) else $error("version changed");
   a_addr_byte: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && !i_xfer.stop && !i_xfer.start && i_xfer.wr_valid && wr_state_r == WR_ADDR)
      |=> index_r == $past(i_xfer.wr_byte) && wr_state_r == WR_DATA) else $error("address byte");
   a_incr: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && wr_data) |=> index_r == 8'($past(index_r) + 8'h01)) else $error("no increment");
   a_no_rd_incr: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && i_xfer.rd_req && !i_xfer.wr_valid) |=> $stable(index_r)) else $error("read moved index");
   a_fuse_load: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && i_fuse_load) |=> version_r == $past(i_fuse.version)) else $error("fuse not loaded");

   // Further guards
   a_ce_freeze: assert property (@(posedge i_clk) disable iff (i_rst)
      !i_ce |=> $stable(ctrl_a_r) && $stable(index_r) && $stable(wr_state_r) && $stable(o_rd_data))
      else $error("state moved while frozen");

   a_stop_idle: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && i_xfer.stop) |=> wr_state_r == WR_IDLE)
      else $error("stop not idle");

   a_start_addr: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && !i_xfer.stop && i_xfer.start) |=> wr_state_r == WR_ADDR)
      else $error("start not address phase");

   a_rd_capture: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && i_xfer.rd_req) |=> o_rd_data == $past(rd_nxt))
      else $error("read data not captured");

   a_rd_hold: assert property (@(posedge i_clk) disable iff (i_rst)
      !(i_ce && i_xfer.rd_req) |=> $stable(o_rd_data))
      else $error("read data moved");

   a_id_write: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && !i_fuse_load && wr_data && index_r == ADDR_PART_IDENTITY) |=> $stable(part_id_r))
      else $error("identity written");

   a_ver_write: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && !i_fuse_load && wr_data && index_r == ADDR_FUSE_VERSION) |=> $stable(version_r))
      else $error("version written");

   a_discharge_off: assert property (@(posedge i_clk) disable iff (i_rst)
      o_reg_a_active |-> !o_reg_a_discharge_on)
      else $error("discharge while active");

   a_enable_on: assert property (@(posedge i_clk) disable iff (i_rst)
      (ctrl_a_r[BIT_ENABLE] && i_en_pin) |-> o_reg_a_active)
      else $error("enabled but off");

   a_ungated_on: assert property (@(posedge i_clk) disable iff (i_rst)
      (ctrl_a_r[BIT_ENABLE] && !ctrl_a_r[BIT_PIN_GATING]) |-> o_reg_a_active)
      else $error("ungated but off");

   a_ctrl_reserved: assert property (@(posedge i_clk) disable iff (i_rst)
      ctrl_a_r[7:4] == 4'h0)
      else $error("reserved control bits set");

   a_flag_set: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && i_sw_int_set != 8'h00)
      |=> (int_sw_r & $past(i_sw_int_set) & MASK_INT_SUB) == ($past(i_sw_int_set) & MASK_INT_SUB))
      else $error("flag set lost");

   a_flag_clear: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && wr_data && index_r == ADDR_SW_INT && i_sw_int_set == 8'h00)
      |=> (int_sw_r & $past(i_xfer.wr_byte)) == 8'h00) else $error("flag not cleared");

   a_reset_pulse: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && o_sw_reset && !(wr_data && index_r == ADDR_SW_RESET)) |=> !o_sw_reset)
      else $error("reset pulse stuck");

   a_pg_b_write: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && wr_data && index_r == ADDR_PG_CFG_B) |=> o_pg_config_b == ($past(i_xfer.wr_byte) & MASK_PG_CFG_B))
      else $error("power good write lost");

   a_unmapped_rd: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && i_xfer.rd_req && index_r > ADDR_LOAD_LOW) |=> o_rd_data == 8'h00)
      else $error("unmapped read not zero");

   a_fuse_ctrl: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && i_fuse_load) |=> ctrl_a_r[BIT_ENABLE] == $past(i_fuse.enable))
      else $error("fuse enable not loaded");

   c_freeze: cover property (@(posedge i_clk) !i_ce && i_xfer.wr_valid);
   c_burst: cover property (@(posedge i_clk) wr_data ##1 wr_data);
   c_gated: cover property (@(posedge i_clk) ctrl_a_r[BIT_PIN_GATING] && o_reg_a_active);
   c_read: cover property (@(posedge i_clk) i_xfer.rd_req && index_r == ADDR_FUSE_VERSION);
   c_fuse: cover property (@(posedge i_clk) i_fuse_load);
endmodule

// file: bench/rcr_host_model.sv
// Host side model: issues register writes and index-based reads on the byte port.
// Assumes the bench calls its tasks after reset with i_clk running.
`timescale 1ns/10ps
module rcr_host_model
   import rcr_pkg::*;
(
   // Clock
   input  wire logic       i_clk,
   // Byte port
   input  wire logic [7:0] i_rd_data,
   output rcr_xfer_type    o_xfer
);
   initial begin
      o_xfer = '0;
   end
   task automatic write(input logic [7:0] a, input logic [7:0] d [$]);
      @(posedge i_clk);
      o_xfer.start <= 1'b1;
      @(posedge i_clk);
      o_xfer.start    <= 1'b0;
      o_xfer.wr_valid <= 1'b1;
      o_xfer.wr_byte  <= a;
      foreach (d[k]) begin
         @(posedge i_clk);
         o_xfer.wr_byte <= d[k];
      end
      @(posedge i_clk);
      o_xfer.wr_valid <= 1'b0;
      o_xfer.wr_byte  <= ~o_xfer.wr_byte;
      o_xfer.stop     <= 1'b1;
      @(posedge i_clk);
      o_xfer.stop <= 1'b0;
   endtask
   task automatic read_again(output logic [7:0] v);
      o_xfer.rd_req <= 1'b1;
      @(posedge i_clk);
      o_xfer.rd_req <= 1'b0;
      @(posedge i_clk);
      #1 v = i_rd_data;
   endtask
   task automatic read(input logic [7:0] a, output logic [7:0] v);
      logic [7:0] none [$];
      write(a, none);
      read_again(v);
   endtask
endmodule

// file: bench/rcr_regs_bench.sv
// Bench for the regulator control register bank.
// Assumes the host model as the only driver of the byte port.
`timescale 1ns/10ps
module rcr_regs_bench;
   import rcr_pkg::*;
   typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp;} rcr_row_type;
   logic         clk;
   logic         rst;
   logic         en_pin;
   logic         fuse_load;
   rcr_fuse_type fuse;
   logic [7:0]   int_a, int_sw, int_lin;
   logic         int_b;
   logic [7:0]   v;
   logic         act;
   logic         ce, reg_on, load_sel;
   rcr_xfer_type xfer;
   logic [7:0]   rd_data, pg_a, pg_b;
   logic         active, fpwm, dis;
   int           error_cnt = 0;
   int           comparisons = 0;
   rcr_row_type  rows [11] = '{'{ADDR_SWITCHER_A, 8'hff, 8'h0f}, '{ADDR_PART_IDENTITY, 8'hff, 8'h42},
      '{ADDR_FUSE_VERSION, 8'hff, 8'h00}, '{ADDR_PG_CFG_A, 8'ha5, 8'ha5}, '{ADDR_PG_CFG_B, 8'hff, 8'h07},
      '{ADDR_TOP_MASK_A, 8'hff, 8'h95}, '{ADDR_LOAD_SEL, 8'hff, 8'h01}, '{ADDR_POWER_GOOD_FAULT_FLAGS, 8'h00, 8'h0f},
      '{ADDR_LOAD_HIGH, 8'h00, 8'h01}, '{ADDR_LOAD_LOW, 8'h00, 8'ha5}, '{8'h40, 8'hff, 8'h00}};
   rcr_host_model host_u (.i_clk(clk), .i_rd_data(rd_data), .o_xfer(xfer));
   rcr_regs dut_u (.i_clk(clk), .i_rst(rst), .i_ce(ce), .i_xfer(xfer), .o_rd_data(rd_data),
      .i_fuse_load(fuse_load), .i_fuse(fuse), .i_en_pin(en_pin), .i_reg_a_on(reg_on), .i_power_good_fault_flags(8'hff),
      .i_top_status(8'h00), .i_sw_status(8'h00), .i_lin_status(8'h00), .i_load_current(9'h1a5),
      .i_top_int_set_a(int_a), .i_top_int_set_b(int_b), .i_sw_int_set(int_sw), .i_lin_int_set(int_lin),
      .o_reg_a_active(active), .o_reg_a_forced_pwm_select(fpwm), .o_reg_a_discharge_on(dis),
      .o_sw_reset(), .o_pg_config_a(pg_a), .o_pg_config_b(pg_b), .o_load_sel(load_sel));
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      host_u.read(a, v);
      check(v, exp);
   endtask
   task automatic final_report();
      $display("Comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      final_report();
   end
   initial begin
      rst = 1'b1; en_pin = 1'b1; fuse_load = 1'b0; fuse = '0; ce = 1'b1; reg_on = 1'b0;
      int_a = 8'h00; int_b = 1'b0; int_sw = 8'h00; int_lin = 8'h00;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1 check(8'(active), 8'h01);
      check(8'(dis), 8'h00);
      rdchk(ADDR_SWITCHER_A, 8'h0f);
      $display("Test reset done");
      foreach (rows[i]) begin
         host_u.write(rows[i].addr, '{rows[i].wdata});
         rdchk(rows[i].addr, rows[i].exp);
      end
      $display("Test rows done");
      for (int c = 0; c < 32; c++) begin
         en_pin <= c[4];
         host_u.write(ADDR_SWITCHER_A, '{8'(c[3:0])});
         #1 act = c[0] && (!c[1] || c[4]);
         check(8'(active), 8'(act));
         check(8'(fpwm), 8'(c[3]));
         check(8'(dis), 8'(c[2] && !act));
      end
      $display("Test control bits done");
      host_u.write(ADDR_PG_CFG_A, '{8'h11, 8'h22});
      check(pg_a, 8'h11);
      check(pg_b, 8'h02);
      rdchk(ADDR_PG_CFG_B, 8'h02);
      host_u.read_again(v);
      check(v, 8'h02);
      $display("Test burst done");
      reg_on <= 1'b1;
      rdchk(ADDR_SW_STATUS, 8'h01);
      check(8'(load_sel), 8'h01);
      ce <= 1'b0;
      host_u.write(ADDR_PG_CFG_A, '{8'h77});
      ce <= 1'b1;
      check(pg_a, 8'h11);
      $display("Test enable and status done");
      @(posedge clk);
      fuse <= '{part_id: 2'b10, version: 8'h5a, forced_pwm: 1'b0, pin_gating: 1'b0, enable: 1'b1};
      fuse_load <= 1'b1;
      @(posedge clk);
      fuse_load <= 1'b0;
      rdchk(ADDR_PART_IDENTITY, 8'hc2);
      rdchk(ADDR_FUSE_VERSION, 8'h5a);
      rdchk(ADDR_SWITCHER_A, 8'h05);
      $display("Test fuse load done");
      @(posedge clk);
      {int_a, int_b, int_sw, int_lin} <= {8'hff, 1'b1, 8'hff, 8'hff};
      @(posedge clk);
      {int_a, int_b, int_sw, int_lin} <= '0;
      rdchk(ADDR_SW_INT, MASK_INT_SUB);
      rdchk(ADDR_LIN_INT, MASK_INT_SUB);
      rdchk(ADDR_TOP_INT_B, 8'h01);
      host_u.write(ADDR_SW_INT, '{8'hff});
      rdchk(ADDR_SW_INT, 8'h00);
      $display("Test flags done");
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rdchk(ADDR_SWITCHER_A, 8'h0f);
      rdchk(ADDR_PART_IDENTITY, 8'h42);
      $display("Test second reset done");
      final_report();
   end
endmodule
